// [hw/lic_defs.vh]
// constants for the line interface configuration register bank
// assumes an apb slave with 32-bit data; register index = byte address / 4
// How it works
// [R1] channel interrupt flags read-only, eight bits, zero at reset, bit n = channel n+1
// [R2] pin direction bits 1 and 0: 0 output, 1 input, both reset to 1
// [R3] output pins drive the stored level bit, levels at bits 3 and 2
// [R4] input pins read back their sampled level in the level bit
// [R5] placement bits 4-3: 00/10 off, 01 transmit path, 11 receive path
// [R6] depth bits 2-1: 00 is 128 bits, 01 is 64, 1x is 32
// [R7] bandwidth bit 0: clear 5/6.8 Hz, set 1.25/0.9 Hz
// [R8] bit 5 selects limit mode with wider bandwidth; resets to 0
// [R9] power-down bit 4 turns transmitter off and its driver high impedance
// [R10] polarity bit 3: clear active high, set active low transmit data
// [R11] clock edge bit 2: clear falling, set rising edge sampling
// [R12] mode 00: single rail data through HDB3/B8ZS encoder and shaper
// [R13] mode 01: single rail data through AMI encoder and shaper
// [R14] mode 1x: encoder bypassed, dual rail data on positive/negative inputs
// [R15] channel registers repeat eight times, 20H apart from channel one
// [R16] global mode bit 4: clear E1, set T1/J1; picks bandwidth value
// [R17] reserved bits read zero; fields take defaults on hard or soft reset
`ifndef LIC_DEFS_VH
`define LIC_DEFS_VH

`define LIC_IDX_JCFG     5'h01
`define LIC_IDX_TCFG     5'h02
`define LIC_IDX_SRST     8'h20
`define LIC_IDX_GCFG     8'h40
`define LIC_IDX_IRQCH    8'h80
`define LIC_IDX_GPIO     8'hA0
`define LIC_IDX_ISTAT    8'hFC
`define LIC_IDX_IMASK    8'hFD

`define LIC_GCFG_MODE    4
`define LIC_JC_LIMIT     5
`define LIC_JC_PL_HI     4
`define LIC_JC_PL_LO     3
`define LIC_JC_DP_HI     2
`define LIC_JC_DP_LO     1
`define LIC_JC_BW        0
`define LIC_TC_OFF       4
`define LIC_TC_INV       3
`define LIC_TC_EDGE      2

`define LIC_JCFG_RST     6'h00
`define LIC_TCFG_RST     5'h00
`define LIC_GPIO_DIR_RST 2'h3
`define LIC_GPIO_LVL_RST 2'h0
`define LIC_GCFG_RST     1'h0
`define LIC_IRQ_RST      3'h0
// edges after reset until the third synchroniser stage holds real pin data
`define LIC_SYNC_WARM    2'h3

`define LIC_DEPTH_128    8'h80
`define LIC_DEPTH_64     8'h40
`define LIC_DEPTH_32     8'h20
// corners in units of 0.01 Hz
`define LIC_BW_T1_NORM   10'h1F4
`define LIC_BW_E1_NORM   10'h2A8
`define LIC_BW_T1_NARR   10'h07D
`define LIC_BW_E1_NARR   10'h05A

`endif

// [hw/lic_config_regs.v]
// configuration and status register bank for an eight-channel line interface
// assumes an apb master on pclk; channel interrupt lines and pins are asynchronous
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps
`include "lic_defs.vh"

module lic_config_regs (
  input  wire        pclk,              // bus clock
  input  wire        presetn,           // async reset, active low
  input  wire        psel,              // apb select
  input  wire        penable,           // apb access phase
  input  wire        pwrite,            // apb direction
  input  wire [11:0] paddr,             // apb byte address
  input  wire [31:0] pwdata,            // apb write data
  output reg  [31:0] prdata,            // apb read data
  output reg         pready,            // apb ready
  output reg         pslverr,           // apb error, unmapped address
  input  wire [7:0]  chan_irq,          // per-channel interrupt levels
  input  wire [1:0]  general_pin_in,    // pin levels, bit 1 pin one
  output reg  [1:0]  general_pin_out,   // pin drive levels
  output reg  [1:0]  general_pin_oe,    // pin drive enables
  output reg         irq,               // interrupt, active high
  output reg         global_line_std,   // 1 t1/j1, 0 e1
  output reg  [7:0]  ja_tx_path,        // attenuator in transmit path
  output reg  [7:0]  ja_rx_path,        // attenuator in receive path
  output reg  [63:0] ja_depth_bits,     // buffer depth, 8 bits per channel
  output reg  [79:0] ja_corner,         // corner in 0.01 Hz, 10 bits per channel
  output reg  [7:0]  jitter_limit_mode, // limit mode per channel
  output reg  [7:0]  tx_power_down,     // transmitter powered down
  output reg  [7:0]  tx_driver_hiz,     // line driver high impedance
  output reg  [7:0]  tx_data_polarity,  // transmit data active low
  output reg  [7:0]  tx_clock_edge_sel, // sample on rising edge
  output reg  [7:0]  tx_enc_hdb3,       // hdb3/b8zs encoder in use
  output reg  [7:0]  tx_enc_ami,        // ami encoder in use
  output reg  [7:0]  tx_dual_rail       // encoder bypassed, dual rail
);

  function chan_hit;
    input [7:0] idx;
    input [4:0] low;
    begin
      chan_hit = (idx[4:0] == low);
    end
  endfunction

  wire [7:0] idx    = paddr[9:2];
  wire       hi_ok  = (paddr[11:10] == 2'h0);
  wire [2:0] ch     = idx[7:5];
  wire       setup  = psel & ~penable;
  wire       wr_acc = psel & penable & pready & pwrite & hi_ok;

  reg  [5:0] jcfg_q [0:7];
  reg  [4:0] tcfg_q [0:7];
  reg        gcfg_q;
  reg  [1:0] dir_q;
  reg  [1:0] lvl_q;
  reg  [2:0] istat_q;
  reg  [2:0] imask_q;
  reg        srst_q;
  reg  [7:0] irq_m_q;
  reg  [7:0] irq_s_q;
  reg  [7:0] irq_p_q;
  reg  [1:0] pin_m_q;
  reg  [1:0] pin_s_q;
  reg  [1:0] pin_p_q;
  reg  [1:0] warm_q;

  // three-stage synchronisers; first stage read only by the second
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_m_q <= 8'h00;
      irq_s_q <= 8'h00;
      irq_p_q <= 8'h00;
      pin_m_q <= 2'h0;
      pin_s_q <= 2'h0;
      pin_p_q <= 2'h0;
    end
    else
    begin
      irq_m_q <= chan_irq;
      irq_s_q <= irq_m_q;
      irq_p_q <= irq_s_q;
      pin_m_q <= general_pin_in;
      pin_s_q <= pin_m_q;
      pin_p_q <= pin_s_q;
    end
  end

  // hold off edge detection until the delayed stage has left its reset value,
  // otherwise a pin idling high would log a false change right after reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      warm_q <= 2'h0;
    else if (warm_q != `LIC_SYNC_WARM)
      warm_q <= warm_q + 2'h1;
  end

  wire sync_ok = (warm_q == `LIC_SYNC_WARM);

  // event sources: input pin changes, any channel interrupt rising
  wire [2:0] ev;
  assign ev[0] = sync_ok & dir_q[0] & (pin_s_q[0] ^ pin_p_q[0]);
  assign ev[1] = sync_ok & dir_q[1] & (pin_s_q[1] ^ pin_p_q[1]);
  assign ev[2] = sync_ok & (|(irq_s_q & ~irq_p_q));

  // software reset: a write to the reset index restores defaults next cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      srst_q <= 1'b0;
    else
      srst_q <= wr_acc & (idx == `LIC_IDX_SRST);
  end

  // per-channel storage and decoded controls
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1)
    begin : g_ch
      wire wr_j = wr_acc & (ch == g) & chan_hit(idx, `LIC_IDX_JCFG); // R15
      wire wr_t = wr_acc & (ch == g) & chan_hit(idx, `LIC_IDX_TCFG); // R15
      wire [5:0] j = jcfg_q[g];
      wire [4:0] t = tcfg_q[g];
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          jcfg_q[g] <= `LIC_JCFG_RST;
          tcfg_q[g] <= `LIC_TCFG_RST;
        end
        else if (srst_q)
        begin
          jcfg_q[g] <= `LIC_JCFG_RST; // R17
          tcfg_q[g] <= `LIC_TCFG_RST; // R17
        end
        else
        begin
          if (wr_j)
            jcfg_q[g] <= pwdata[5:0]; // R17
          if (wr_t)
            tcfg_q[g] <= pwdata[4:0]; // R17
        end
      end
      always @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          ja_tx_path[g]            <= 1'b0;
          ja_rx_path[g]            <= 1'b0;
          ja_depth_bits[g*8 +: 8]  <= `LIC_DEPTH_128;
          ja_corner[g*10 +: 10]    <= `LIC_BW_E1_NORM;
          jitter_limit_mode[g]     <= 1'b0;
          tx_power_down[g]         <= 1'b0;
          tx_driver_hiz[g]         <= 1'b0;
          tx_data_polarity[g]      <= 1'b0;
          tx_clock_edge_sel[g]     <= 1'b0;
          tx_enc_hdb3[g]           <= 1'b1;
          tx_enc_ami[g]            <= 1'b0;
          tx_dual_rail[g]          <= 1'b0;
        end
        else
        begin
          // placement: msb only matters with lsb set
          ja_tx_path[g] <= j[`LIC_JC_PL_LO] & ~j[`LIC_JC_PL_HI]; // R5
          ja_rx_path[g] <= j[`LIC_JC_PL_LO] & j[`LIC_JC_PL_HI]; // R5
          case (j[`LIC_JC_DP_HI:`LIC_JC_DP_LO])
            2'h0:    ja_depth_bits[g*8 +: 8] <= `LIC_DEPTH_128; // R6
            2'h1:    ja_depth_bits[g*8 +: 8] <= `LIC_DEPTH_64; // R6
            default: ja_depth_bits[g*8 +: 8] <= `LIC_DEPTH_32; // R6
          endcase
          case ({gcfg_q, j[`LIC_JC_BW]})
            2'h0:    ja_corner[g*10 +: 10] <= `LIC_BW_E1_NORM; // R7 R16
            2'h1:    ja_corner[g*10 +: 10] <= `LIC_BW_E1_NARR; // R7 R16
            2'h2:    ja_corner[g*10 +: 10] <= `LIC_BW_T1_NORM; // R7 R16
            default: ja_corner[g*10 +: 10] <= `LIC_BW_T1_NARR; // R7 R16
          endcase
          jitter_limit_mode[g] <= j[`LIC_JC_LIMIT]; // R8
          tx_power_down[g]     <= t[`LIC_TC_OFF]; // R9
          tx_driver_hiz[g]     <= t[`LIC_TC_OFF]; // R9
          tx_data_polarity[g]  <= t[`LIC_TC_INV]; // R10
          tx_clock_edge_sel[g] <= t[`LIC_TC_EDGE]; // R11
          tx_enc_hdb3[g]       <= (t[1:0] == 2'h0); // R12
          tx_enc_ami[g]        <= (t[1:0] == 2'h1); // R13
          tx_dual_rail[g]      <= t[1]; // R14
        end
      end
    end
  endgenerate

  // global, pin and interrupt registers
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gcfg_q  <= `LIC_GCFG_RST;
      dir_q   <= `LIC_GPIO_DIR_RST;
      lvl_q   <= `LIC_GPIO_LVL_RST;
      imask_q <= `LIC_IRQ_RST;
      istat_q <= `LIC_IRQ_RST;
    end
    else if (srst_q)
    begin
      gcfg_q  <= `LIC_GCFG_RST; // R17
      dir_q   <= `LIC_GPIO_DIR_RST; // R2 R17
      lvl_q   <= `LIC_GPIO_LVL_RST;
      imask_q <= `LIC_IRQ_RST;
      istat_q <= `LIC_IRQ_RST;
    end
    else
    begin
      if (wr_acc & (idx == `LIC_IDX_GCFG))
        gcfg_q <= pwdata[`LIC_GCFG_MODE]; // R16
      if (wr_acc & (idx == `LIC_IDX_GPIO))
      begin
        dir_q <= pwdata[1:0]; // R2
        lvl_q <= pwdata[3:2]; // R3
      end
      if (wr_acc & (idx == `LIC_IDX_IMASK))
        imask_q <= pwdata[2:0];
      // set wins over a same-cycle clear
      if (wr_acc & (idx == `LIC_IDX_ISTAT))
        istat_q <= (istat_q & ~pwdata[2:0]) | ev;
      else
        istat_q <= istat_q | ev;
    end
  end

  // pin drivers and interrupt output
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      general_pin_out <= 2'h0;
      general_pin_oe  <= 2'h0;
      irq             <= 1'b0;
      global_line_std <= 1'b0;
    end
    else
    begin
      general_pin_out <= lvl_q; // R3
      general_pin_oe  <= ~dir_q; // R2 R3
      irq             <= |(istat_q & imask_q);
      global_line_std <= gcfg_q; // R16
    end
  end

  // read data for the addressed register
  reg [7:0] rd_d;
  reg       err_d;
  always @*
  begin
    rd_d  = 8'h00;
    err_d = ~hi_ok;
    if (hi_ok)
    begin
      if (chan_hit(idx, `LIC_IDX_JCFG))
        rd_d = {2'h0, jcfg_q[ch]}; // R15 R17
      else if (chan_hit(idx, `LIC_IDX_TCFG))
        rd_d = {3'h0, tcfg_q[ch]}; // R15 R17
      else
        case (idx)
          `LIC_IDX_SRST:  rd_d = 8'h00;
          `LIC_IDX_GCFG:  rd_d = {3'h0, gcfg_q, 4'h0};
          `LIC_IDX_IRQCH: rd_d = irq_s_q; // R1
          // input pins show their sampled level
          `LIC_IDX_GPIO:  rd_d = {4'h0, (dir_q & pin_s_q) | (~dir_q & lvl_q), dir_q}; // R4
          `LIC_IDX_ISTAT: rd_d = {5'h00, istat_q};
          `LIC_IDX_IMASK: rd_d = {5'h00, imask_q};
          default:        err_d = 1'b1;
        endcase
    end
  end

  // zero-wait apb: ready in the first access cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      pslverr <= setup & err_d;
      if (setup & ~pwrite)
        prdata <= {24'h000000, rd_d};
      else
        prdata <= 32'h0000_0000;
    end
  end

endmodule

// [dv/lic_config_regs_assertions.sv]
// assertions on the ports of the line interface register bank
// assumes apb transfers whose write lands at the edge sampling pready
`timescale 1ns/1ps
module lic_config_regs_chk (
  input logic        pclk,              // clock
  input logic        presetn,           // reset
  input logic        psel,              // apb
  input logic        penable,           // apb
  input logic        pwrite,            // apb
  input logic [11:0] paddr,             // apb
  input logic [31:0] pwdata,            // apb
  input logic [31:0] prdata,            // apb
  input logic        pready,            // apb
  input logic        pslverr,           // apb
  input logic        irq,               // interrupt
  input logic [1:0]  general_pin_out,   // pins
  input logic [1:0]  general_pin_oe,    // pins
  input logic        global_line_std,   // mode
  input logic [7:0]  ja_tx_path,        // jitter
  input logic [7:0]  ja_rx_path,        // jitter
  input logic [63:0] ja_depth_bits,     // jitter
  input logic [79:0] ja_corner,         // jitter
  input logic [7:0]  jitter_limit_mode, // jitter
  input logic [7:0]  tx_power_down,     // tx
  input logic [7:0]  tx_driver_hiz,     // tx
  input logic [7:0]  tx_data_polarity,  // tx
  input logic [7:0]  tx_clock_edge_sel, // tx
  input logic [7:0]  tx_enc_hdb3,       // tx
  input logic [7:0]  tx_enc_ami,        // tx
  input logic [7:0]  tx_dual_rail       // tx
);
  logic [7:0] wd_q;
  wire        wr = psel && penable && pready && pwrite && paddr[11:10] == 2'h0;
  wire [7:0]  ix = paddr[9:2];
  always @(posedge pclk or negedge presetn)
    if (!presetn)
      wd_q <= 8'h00;
    else if (wr)
      wd_q <= pwdata[7:0];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_flags;
    psel && penable && pready && !pwrite && ix == 8'h80 |-> prdata[31:8] == 24'h0;
  endproperty
  a_flags: assert property (p_flags) else $error("flag read upper bits");
  property p_pin_dir;
    wr && ix == 8'hA0 |=> ##[0:1] general_pin_oe == ~wd_q[1:0];
  endproperty
  a_pin_dir: assert property (p_pin_dir) else $error("pin direction");
  property p_pin_lvl;
    wr && ix == 8'hA0 && pwdata[1:0] == 2'h0 |=> ##[0:1] general_pin_out == wd_q[3:2];
  endproperty
  a_pin_lvl: assert property (p_pin_lvl) else $error("pin drive level");
  property p_jplace;
    wr && ix == 8'h01 |=> ##[0:1] {ja_tx_path[0], ja_rx_path[0], jitter_limit_mode[0]}
      == {wd_q[4:3] == 2'h1, wd_q[4:3] == 2'h3, wd_q[5]};
  endproperty
  a_jplace: assert property (p_jplace) else $error("jitter placement");
  property p_jdepth;
    wr && ix == 8'h01 |=> ##[0:1] ja_depth_bits[7:0] ==
      (wd_q[2:1] == 2'h0 ? 8'h80 : (wd_q[2:1] == 2'h1 ? 8'h40 : 8'h20));
  endproperty
  a_jdepth: assert property (p_jdepth) else $error("jitter depth");
  property p_jbw;
    wr && ix == 8'h01 |=> ##[0:1] ja_corner[9:0] == (wd_q[0] ?
      (global_line_std ? 10'h07D : 10'h05A) : (global_line_std ? 10'h1F4 : 10'h2A8));
  endproperty
  a_jbw: assert property (p_jbw) else $error("jitter corner");
  property p_gmode;
    wr && ix == 8'h40 |=> ##[0:1] global_line_std == wd_q[4];
  endproperty
  a_gmode: assert property (p_gmode) else $error("line standard");
  property p_tx;
    wr && ix == 8'h22 |=> ##[0:1] {tx_power_down[1], tx_data_polarity[1], tx_clock_edge_sel[1],
      tx_enc_hdb3[1], tx_enc_ami[1], tx_dual_rail[1]}
      == {wd_q[4:2], wd_q[1:0] == 2'h0, wd_q[1:0] == 2'h1, wd_q[1]};
  endproperty
  a_tx: assert property (p_tx) else $error("transmit config");
  property p_hiz;
    wr && ix == 8'h02 |=> ##[0:1] {tx_driver_hiz[0], tx_power_down[0]} == {2{wd_q[4]}};
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver high impedance");
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
  c_jrx: cover property (ja_rx_path[0]);
endmodule

bind lic_config_regs lic_config_regs_chk u_chk (.*);

// [dv/lic_config_regs_tb.sv]
// self-checking bench for the line interface register bank
// assumes an apb slave; bench drives pins and channel interrupt lines
`timescale 1ns/1ps
module lic_config_regs_tb;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [7:0]  chan_irq, ja_tx_path, ja_rx_path, jitter_limit_mode, tx_power_down;
  logic [7:0]  tx_driver_hiz, tx_data_polarity, tx_clock_edge_sel, tx_enc_hdb3;
  logic [7:0]  tx_enc_ami, tx_dual_rail;
  logic [1:0]  general_pin_in, general_pin_out, general_pin_oe;
  logic        global_line_std;
  logic [63:0] ja_depth_bits;
  logic [79:0] ja_corner;
  int          failures, n_checks;
  lic_config_regs uut (.*);
  always #5 pclk = ~pclk;
  task automatic chk(input string nm, input logic [79:0] e, input logic [79:0] g);
    n_checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input string nm);
    apb(1'b0, a, 8'h00);
    chk(nm, {72'h0, e}, {48'h0, rdat});
  endtask
  task automatic settle;
    repeat (3) @(negedge pclk);
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    #100000;
    failures++;
    close_out;
  end
  initial
  begin
    logic [7:0] d;
    logic [7:0] e;
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    chan_irq = 8'h00;
    general_pin_in = 2'b10;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(12'h200, 8'h00, "flags");
    rd(12'h280, 8'h0B, "pins");
    rd(12'h004, 8'h00, "jitter_cfg");
    chk("pin_oe", 80'h0, {78'h0, general_pin_oe});
    chan_irq <= 8'hA5;
    settle;
    rd(12'h200, 8'hA5, "flags");
    apb(1'b1, 12'h200, 8'hFF);
    rd(12'h200, 8'hA5, "flags");
    chan_irq <= 8'h00;
    $display("test flags done");
    apb(1'b1, 12'h280, 8'hF8);
    settle;
    rd(12'h280, 8'h08, "pins");
    chk("pin_drive", {76'h0, 4'hE}, {76'h0, general_pin_oe, general_pin_out});
    $display("test pins done");
    for (int g = 0; g < 2; g++)
    begin
      apb(1'b1, 12'h100, g ? 8'h10 : 8'h00);
      for (int n = 0; n < 8; n++)
      begin
        d = 8'(n * 13);
        apb(1'b1, 12'h004 + 12'(n * 128), d);
        settle;
        rd(12'h004 + 12'(n * 128), d & 8'h3F, "jitter_cfg");
        chk("jitter_out", {59'h0, d[4:3] == 2'h1, d[4:3] == 2'h3, d[5],
          d[2:1] == 2'h0 ? 8'h80 : (d[2:1] == 2'h1 ? 8'h40 : 8'h20),
          d[0] ? (g ? 10'h07D : 10'h05A) : (g ? 10'h1F4 : 10'h2A8)},
          {59'h0, ja_tx_path[n], ja_rx_path[n], jitter_limit_mode[n],
          ja_depth_bits[8*n +: 8], ja_corner[10*n +: 10]});
        chk("line_std", 80'(g), {79'h0, global_line_std});
      end
    end
    $display("test jitter done");
    for (int n = 0; n < 8; n++)
    begin
      e = 8'(n * 7) & 8'h1F;
      apb(1'b1, 12'h008 + 12'(n * 128), 8'(n * 7) | 8'hE0);
      settle;
      rd(12'h008 + 12'(n * 128), e, "tx_cfg");
      chk("tx_out", {73'h0, e[4], e[4], e[3], e[2], e[1:0] == 2'h0, e[1:0] == 2'h1, e[1]},
        {73'h0, tx_power_down[n], tx_driver_hiz[n], tx_data_polarity[n], tx_clock_edge_sel[n],
        tx_enc_hdb3[n], tx_enc_ami[n], tx_dual_rail[n]});
    end
    $display("test transmit done");
    apb(1'b0, 12'h00C, 8'h00);
    chk("unmapped", {47'h0, 1'b1, 32'h0}, {47'h0, rerr, rdat});
    apb(1'b1, 12'h080, 8'h00);
    settle;
    chk("depth", {16'h0, {8{8'h80}}}, {16'h0, ja_depth_bits});
    rd(12'h280, 8'h0B, "pins");
    $display("test soft reset done");
    apb(1'b1, 12'h3F0, 8'h07);
    @(posedge pclk);
    general_pin_in <= 2'b11;
    settle;
    chk("irq_masked", 80'h0, {79'h0, irq});
    apb(1'b1, 12'h3F4, 8'h01);
    settle;
    chk("irq_set", 80'h1, {79'h0, irq});
    apb(1'b1, 12'h3F0, 8'h01);
    settle;
    chk("irq_clear", 80'h0, {79'h0, irq});
    chan_irq <= 8'h02;
    settle;
    rd(12'h3F0, 8'h04, "status");
    apb(1'b1, 12'h3F4, 8'h04);
    settle;
    chk("irq_chan", 80'h1, {79'h0, irq});
    $display("test interrupt done");
    close_out;
  end
endmodule
